// [rtl/uart_line_pkg.sv]
`default_nettype none
package uart_line_pkg;

    // Channel count and character width
    localparam int unsigned NUM_CH     = 3;
    localparam int unsigned CHAR_W     = 8;
    localparam int unsigned CH_TWO     = 2;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL0   = 8'h00;
    localparam logic [7:0] OFS_CTRL1   = 8'h04;
    localparam logic [7:0] OFS_CTRL2   = 8'h08;
    localparam logic [7:0] OFS_DIR     = 8'h0C;
    localparam logic [7:0] OFS_PORT    = 8'h10;
    localparam logic [7:0] OFS_PIN     = 8'h14;
    localparam logic [7:0] OFS_RXBUF0  = 8'h20;
    localparam logic [7:0] OFS_RXBUF1  = 8'h24;
    localparam logic [7:0] OFS_RXBUF2  = 8'h28;
    localparam logic [7:0] OFS_TXBUF0  = 8'h30;
    localparam logic [7:0] OFS_TXBUF1  = 8'h34;
    localparam logic [7:0] OFS_TXBUF2  = 8'h38;
    localparam logic [7:0] OFS_STATUS  = 8'h40;
    localparam logic [7:0] OFS_MASK    = 8'h44;

    // Control register field positions
    localparam int unsigned B_HS_FUNC  = 2;
    localparam int unsigned B_CLK_EXT  = 3;
    localparam int unsigned B_HS_DIS   = 4;
    localparam int unsigned B_INVERT   = 6;
    localparam int unsigned B_SLEEP    = 7;
    localparam int unsigned B_POLREV   = 8;
    localparam int unsigned B_COLL_EN  = 9;
    localparam int unsigned CTRL_W     = 10;

    // Direction and port layout: channel c uses bits 4c+0..4c+2
    localparam int unsigned DIR_STRIDE = 4;
    localparam int unsigned D_RX       = 0;
    localparam int unsigned D_CLK      = 1;
    localparam int unsigned D_HS       = 2;
    localparam int unsigned DIR_W      = 12;

    // Status layout: bits 0..2 receive complete, bit 3 bus collision
    localparam int unsigned S_COLL     = 3;
    localparam int unsigned STAT_W     = 4;

    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
    localparam logic [DIR_W-1:0]  DIR_RST  = 12'h000;
    localparam logic [STAT_W-1:0] STAT_RST = 4'h0;

endpackage
`default_nettype wire

// [rtl/uart_pin_route.sv]
`default_nettype none
// Pin function routing for one channel
module uart_pin_route
    import uart_line_pkg::*;
#(
    parameter bit EXT_CLK_OK = 1'b1
)(
    // Configuration
    input  wire logic       clk_ext_i,
    input  wire logic       hs_func_i,
    input  wire logic       hs_dis_i,
    input  wire logic       polrev_i,
    input  wire logic [2:0] dir_i,
    input  wire logic [2:0] port_i,
    // Engine side
    input  wire logic       eng_txd_i,
    input  wire logic       eng_rts_n_i,
    output logic            eng_rxd_o,
    output logic            eng_cts_n_o,
    output logic            eng_ext_clk_o,
    output logic            eng_ext_sel_o,
    // Pins
    output logic            serial_out_pin_o,
    input  wire logic       serial_in_pin_i,
    input  wire logic       clk_pin_i,
    output logic            clk_pin_o,
    output logic            clk_pin_oe_o,
    input  wire logic       hs_pin_i,
    output logic            hs_pin_o,
    output logic            hs_pin_oe_o
);
    // External clock only where the channel allows it
    logic ext_sel;

    always_comb
    begin
        // Transmit pin always belongs to the serial function
        serial_out_pin_o = eng_txd_i ^ polrev_i;
        // Receive input counts only with direction cleared; else idle mark
        if (!dir_i[D_RX])
        begin
            eng_rxd_o = serial_in_pin_i ^ polrev_i;
        end
        else
        begin
            eng_rxd_o = 1'b1;
        end
        // Channel two hardwires internal clock so a stray bit cannot lock it
        ext_sel       = clk_ext_i && EXT_CLK_OK;
        eng_ext_sel_o = ext_sel;
        if (ext_sel && !dir_i[D_CLK])
        begin
            eng_ext_clk_o = clk_pin_i;
            clk_pin_o     = 1'b0;
            clk_pin_oe_o  = 1'b0;
        end
        else
        begin
            eng_ext_clk_o = 1'b0;
            clk_pin_o     = port_i[D_CLK];
            clk_pin_oe_o  = dir_i[D_CLK] && !ext_sel;
        end
        // Handshake pin role
        eng_cts_n_o = 1'b0;
        if (hs_dis_i)
        begin
            hs_pin_o    = port_i[D_HS];
            hs_pin_oe_o = dir_i[D_HS];
        end
        else if (hs_func_i)
        begin
            hs_pin_o    = eng_rts_n_i;
            hs_pin_oe_o = 1'b1;
        end
        else
        begin
            hs_pin_o    = 1'b0;
            hs_pin_oe_o = 1'b0;
            // Clear-to-send needs an input pin; otherwise sending is allowed
            eng_cts_n_o = dir_i[D_HS] ? 1'b0 : hs_pin_i;
        end
    end

endmodule
`default_nettype wire

// [rtl/uart_line_opts.sv]
// Summary of operation
// - Receive pin feeds receiver only when input
// - Internal clock frees clock pin as port
// - External clock taken on input pin; never channel two
// - Handshake bit selects clear-to-send or request-to-send
// - Handshake disable returns pin to port use
// - Sleep bit enables address filtering, channels zero/one
// - In sleep keep characters with MSB one only
// - Channel two inverts written and read character bits
// - Inversion touches character bits, not framing bits
// - Polarity reversal inverts channel two serial out and in levels only
// - Sample out and in levels at clock rise
// - Differing levels raise a bus collision request
`default_nettype none
module uart_line_opts
    import uart_line_pkg::*;
(
    // Clock and reset
    input  wire logic                             clock_i,
    input  wire logic                             rstn_i,
    // APB slave
    input  wire logic                             psel_i,
    input  wire logic                             penable_i,
    input  wire logic                             pwrite_i,
    input  wire logic [7:0]                       paddr_i,
    input  wire logic [31:0]                      pwdata_i,
    output logic      [31:0]                      prdata_o,
    output logic                                  pready_o,
    output logic                                  pslverr_o,
    // Serial engine side
    input  wire logic [NUM_CH-1:0]                eng_txd_i,
    input  wire logic [NUM_CH-1:0]                eng_rts_n_i,
    input  wire logic [NUM_CH-1:0]                rx_valid_i,
    input  wire logic [NUM_CH-1:0][CHAR_W-1:0]    rx_char_i,
    input  wire logic                             xfer_clk_rise_i,
    output logic      [NUM_CH-1:0]                eng_rxd_o,
    output logic      [NUM_CH-1:0]                eng_cts_n_o,
    output logic      [NUM_CH-1:0]                eng_ext_clk_o,
    output logic      [NUM_CH-1:0]                eng_ext_sel_o,
    output logic      [NUM_CH-1:0][CHAR_W-1:0]    tx_data_o,
    output logic      [NUM_CH-1:0]                tx_load_o,
    // Pins
    output logic      [NUM_CH-1:0]                serial_out_pin_o,
    input  wire logic [NUM_CH-1:0]                serial_in_pin_i,
    input  wire logic [NUM_CH-1:0]                transfer_clock_pin_i,
    output logic      [NUM_CH-1:0]                transfer_clock_pin_o,
    output logic      [NUM_CH-1:0]                transfer_clock_pin_oe_o,
    input  wire logic [NUM_CH-1:0]                hs_pin_i,
    output logic      [NUM_CH-1:0]                hs_pin_o,
    output logic      [NUM_CH-1:0]                hs_pin_oe_o,
    // Interrupt
    output logic                                  irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // State
    logic [NUM_CH-1:0][CTRL_W-1:0]  ctrl;        // Per-channel control
    logic [DIR_W-1:0]               dir;         // Pin directions, 1 = out
    logic [DIR_W-1:0]               port;        // Port output levels
    logic [NUM_CH-1:0][CHAR_W-1:0]  rx_buf;      // Receive buffers
    logic [STAT_W-1:0]              status;      // Sticky events
    logic [STAT_W-1:0]              mask;        // Interrupt enables
    logic [NUM_CH-1:0][CTRL_W-1:0]  next_ctrl;
    logic [DIR_W-1:0]               next_dir;
    logic [DIR_W-1:0]               next_port;
    logic [NUM_CH-1:0][CHAR_W-1:0]  next_rx_buf;
    logic [NUM_CH-1:0][CHAR_W-1:0]  next_tx_data;
    logic [NUM_CH-1:0]              next_tx_load;
    logic [STAT_W-1:0]              next_status;
    logic [STAT_W-1:0]              next_mask;

    // Decoded access
    logic                           wr_en;       // Write access phase
    logic                           rd_en;       // Read access phase
    logic                           hit;         // Address is mapped
    logic [NUM_CH-1:0]              rx_take;     // Character accepted
    logic                           collide;     // Collision this edge
    logic [DIR_W-1:0]               pin_lvl;     // Pin levels for reading

    assign wr_en     = psel_i && penable_i && pwrite_i;
    assign rd_en     = psel_i && penable_i && !pwrite_i;
    // Zero wait states: every access finishes in its first access cycle
    assign pready_o  = psel_i && penable_i;
    assign pslverr_o = psel_i && penable_i && !hit;

    ////////////////////////////////////////////////////////////////////////
    // Pin routing, one instance per channel
    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_ch
        uart_pin_route #(
            .EXT_CLK_OK (c != CH_TWO)
        ) u_route (
            .clk_ext_i        (ctrl[c][B_CLK_EXT]),
            .hs_func_i        (ctrl[c][B_HS_FUNC]),
            .hs_dis_i         (ctrl[c][B_HS_DIS]),
            .polrev_i         ((c == CH_TWO) && ctrl[c][B_POLREV]),
            .dir_i            (dir[c*DIR_STRIDE +: 3]),
            .port_i           (port[c*DIR_STRIDE +: 3]),
            .eng_txd_i        (eng_txd_i[c]),
            .eng_rts_n_i      (eng_rts_n_i[c]),
            .eng_rxd_o        (eng_rxd_o[c]),
            .eng_cts_n_o      (eng_cts_n_o[c]),
            .eng_ext_clk_o    (eng_ext_clk_o[c]),
            .eng_ext_sel_o    (eng_ext_sel_o[c]),
            .serial_out_pin_o (serial_out_pin_o[c]),
            .serial_in_pin_i  (serial_in_pin_i[c]),
            .clk_pin_i        (transfer_clock_pin_i[c]),
            .clk_pin_o        (transfer_clock_pin_o[c]),
            .clk_pin_oe_o     (transfer_clock_pin_oe_o[c]),
            .hs_pin_i         (hs_pin_i[c]),
            .hs_pin_o         (hs_pin_o[c]),
            .hs_pin_oe_o      (hs_pin_oe_o[c])
        );
        // Readable pin levels; receive pin usable as plain input
        assign pin_lvl[c*DIR_STRIDE + D_RX]  = serial_in_pin_i[c];
        assign pin_lvl[c*DIR_STRIDE + D_CLK] = transfer_clock_pin_i[c];
        assign pin_lvl[c*DIR_STRIDE + D_HS]  = hs_pin_i[c];
        assign pin_lvl[c*DIR_STRIDE + 3]     = 1'b0;
        // Sleep filter: only channels zero and one, MSB must be one
        assign rx_take[c] = rx_valid_i[c] &&
            (c == CH_TWO || !ctrl[c][B_SLEEP] || rx_char_i[c][CHAR_W-1]);
    end

    // Raw pin levels compared, so polarity reversal cannot hide a clash
    assign collide = xfer_clk_rise_i && ctrl[CH_TWO][B_COLL_EN] &&
                     (serial_out_pin_o[CH_TWO] != serial_in_pin_i[CH_TWO]);

    assign irq_o = |(status & mask);

    ////////////////////////////////////////////////////////////////////////
    // Read decode
    always_comb
    begin
        prdata_o = 32'h0000_0000;
        hit      = 1'b1;
        if (paddr_i == OFS_CTRL0)
        begin
            prdata_o[CTRL_W-1:0] = ctrl[0];
        end
        else if (paddr_i == OFS_CTRL1)
        begin
            prdata_o[CTRL_W-1:0] = ctrl[1];
        end
        else if (paddr_i == OFS_CTRL2)
        begin
            prdata_o[CTRL_W-1:0] = ctrl[2];
        end
        else if (paddr_i == OFS_DIR)
        begin
            prdata_o[DIR_W-1:0] = dir;
        end
        else if (paddr_i == OFS_PORT)
        begin
            prdata_o[DIR_W-1:0] = port;
        end
        else if (paddr_i == OFS_PIN)
        begin
            prdata_o[DIR_W-1:0] = pin_lvl;
        end
        else if (paddr_i == OFS_RXBUF0)
        begin
            prdata_o[CHAR_W-1:0] = rx_buf[0];
        end
        else if (paddr_i == OFS_RXBUF1)
        begin
            prdata_o[CHAR_W-1:0] = rx_buf[1];
        end
        else if (paddr_i == OFS_RXBUF2)
        begin
            // Inverted on read; the engine framing stays untouched
            prdata_o[CHAR_W-1:0] = ctrl[CH_TWO][B_INVERT] ? ~rx_buf[2] : rx_buf[2];
        end
        else if (paddr_i == OFS_TXBUF0 || paddr_i == OFS_TXBUF1 || paddr_i == OFS_TXBUF2)
        begin
            // Transmit buffers are write only
            prdata_o = 32'h0000_0000;
        end
        else if (paddr_i == OFS_STATUS)
        begin
            prdata_o[STAT_W-1:0] = status;
        end
        else if (paddr_i == OFS_MASK)
        begin
            prdata_o[STAT_W-1:0] = mask;
        end
        else
        begin
            hit = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic for registers, buffers and events
    always_comb
    begin
        next_ctrl    = ctrl;
        next_dir     = dir;
        next_port    = port;
        next_mask    = mask;
        next_rx_buf  = rx_buf;
        next_tx_data = tx_data_o;
        next_tx_load = '0;
        next_status  = status;
        // Software side; write-one clears come first so events can win
        if (wr_en)
        begin
            if (paddr_i == OFS_CTRL0)
            begin
                next_ctrl[0] = pwdata_i[CTRL_W-1:0];
            end
            else if (paddr_i == OFS_CTRL1)
            begin
                next_ctrl[1] = pwdata_i[CTRL_W-1:0];
            end
            else if (paddr_i == OFS_CTRL2)
            begin
                next_ctrl[2] = pwdata_i[CTRL_W-1:0];
            end
            else if (paddr_i == OFS_DIR)
            begin
                next_dir = pwdata_i[DIR_W-1:0];
            end
            else if (paddr_i == OFS_PORT)
            begin
                next_port = pwdata_i[DIR_W-1:0];
            end
            else if (paddr_i == OFS_TXBUF0)
            begin
                next_tx_data[0] = pwdata_i[CHAR_W-1:0];
                next_tx_load[0] = 1'b1;
            end
            else if (paddr_i == OFS_TXBUF1)
            begin
                next_tx_data[1] = pwdata_i[CHAR_W-1:0];
                next_tx_load[1] = 1'b1;
            end
            else if (paddr_i == OFS_TXBUF2)
            begin
                // Only character bits are inverted; engine adds framing later
                next_tx_data[2] = ctrl[CH_TWO][B_INVERT] ?
                                  ~pwdata_i[CHAR_W-1:0] : pwdata_i[CHAR_W-1:0];
                next_tx_load[2] = 1'b1;
            end
            else if (paddr_i == OFS_STATUS)
            begin
                next_status = status & ~pwdata_i[STAT_W-1:0];
            end
            else if (paddr_i == OFS_MASK)
            begin
                next_mask = pwdata_i[STAT_W-1:0];
            end
        end
        // Hardware events override a same-cycle clear
        for (int c = 0; c < NUM_CH; c++)
        begin
            if (rx_take[c])
            begin
                next_rx_buf[c] = rx_char_i[c];
                next_status[c] = 1'b1;
            end
        end
        if (collide)
        begin
            next_status[S_COLL] = 1'b1;
        end
    end

    // Register stage
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ctrl      <= {NUM_CH{CTRL_RST}};
            dir       <= DIR_RST;
            port      <= DIR_RST;
            mask      <= STAT_RST;
            status    <= STAT_RST;
            rx_buf    <= '0;
            tx_data_o <= '0;
            tx_load_o <= '0;
        end
        else
        begin
            ctrl      <= next_ctrl;
            dir       <= next_dir;
            port      <= next_port;
            mask      <= next_mask;
            status    <= next_status;
            rx_buf    <= next_rx_buf;
            tx_data_o <= next_tx_data;
            tx_load_o <= next_tx_load;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    chk_sleep_drop: assert property (@(posedge clock_i) disable iff (!rstn_i)
        rx_valid_i[0] && ctrl[0][B_SLEEP] && !rx_char_i[0][CHAR_W-1] |=> $stable(rx_buf[0]))
        else $error("sleep mode kept a character with MSB zero");
    chk_sleep_keep: assert property (@(posedge clock_i) disable iff (!rstn_i)
        rx_valid_i[1] && rx_char_i[1][CHAR_W-1] |=> rx_buf[1] == $past(rx_char_i[1]) && status[1])
        else $error("address character not received");
    chk_tx_invert: assert property (@(posedge clock_i) disable iff (!rstn_i)
        wr_en && paddr_i == OFS_TXBUF2 && ctrl[2][B_INVERT]
        |=> tx_load_o[2] && tx_data_o[2] == ~$past(pwdata_i[CHAR_W-1:0]))
        else $error("channel two transmit data not inverted");
    chk_tx_plain0: assert property (@(posedge clock_i) disable iff (!rstn_i)
        wr_en && paddr_i == OFS_TXBUF0 |=> tx_data_o[0] == $past(pwdata_i[CHAR_W-1:0]))
        else $error("channel zero transmit data altered");
    chk_pol_path: assert property (@(posedge clock_i) disable iff (!rstn_i)
        ctrl[2][B_POLREV] && !dir[2*DIR_STRIDE + D_RX]
        |-> serial_out_pin_o[2] != eng_txd_i[2] && eng_rxd_o[2] != serial_in_pin_i[2])
        else $error("polarity reversal not applied");
    chk_rx_dir: assert property (@(posedge clock_i) disable iff (!rstn_i)
        dir[D_RX] |-> eng_rxd_o[0])
        else $error("receiver fed from an output pin");
    chk_clk_ext: assert property (@(posedge clock_i) disable iff (!rstn_i)
        !eng_ext_sel_o[2] && !eng_ext_clk_o[2] && !transfer_clock_pin_oe_o[0] ||
        !ctrl[0][B_CLK_EXT])
        else $error("external clock misrouted");
    chk_clk_port: assert property (@(posedge clock_i) disable iff (!rstn_i)
        !ctrl[1][B_CLK_EXT] |-> transfer_clock_pin_oe_o[1] == dir[DIR_STRIDE + D_CLK])
        else $error("clock pin not a port under internal clock");
    chk_rts_role: assert property (@(posedge clock_i) disable iff (!rstn_i)
        !ctrl[0][B_HS_DIS] && ctrl[0][B_HS_FUNC] |-> hs_pin_oe_o[0] && hs_pin_o[0] == eng_rts_n_i[0])
        else $error("request-to-send not driven");
    chk_coll_irq: assert property (@(posedge clock_i) disable iff (!rstn_i)
        xfer_clk_rise_i && ctrl[2][B_COLL_EN] && serial_out_pin_o[2] != serial_in_pin_i[2]
        && mask[S_COLL] |=> status[S_COLL] && (irq_o || !mask[S_COLL]))
        else $error("bus collision not flagged");
    cov_sleep_drop: cover property (@(posedge clock_i) disable iff (!rstn_i)
        rx_valid_i[0] && ctrl[0][B_SLEEP] && !rx_char_i[0][CHAR_W-1]);
    cov_collision: cover property (@(posedge clock_i) disable iff (!rstn_i) collide ##1 irq_o);
    cov_inv_read: cover property (@(posedge clock_i) disable iff (!rstn_i)
        rd_en && paddr_i == OFS_RXBUF2 && ctrl[2][B_INVERT]);

endmodule
`default_nettype wire

// [tb/remote_node.sv]
`default_nettype none
// Remote serial node on the shared channel two line
module remote_node
(
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic rstn_i,
    // Line side
    input  wire logic line_i,
    input  wire logic collide_i,
    output logic      line_o,
    output logic      rise_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] div; // Transfer clock divider

    // Shared line reads back what is driven, unless this node fights it
    assign line_o = collide_i ? ~line_i : line_i;

    // Transfer clock rises every fourth cycle, slow enough to see each one
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            div <= 2'h0;
        else
            div <= div + 2'h1;
    end
    assign rise_o = (div == 2'h3);
endmodule
`default_nettype wire

// [tb/tb.sv]
`default_nettype none
module tb import uart_line_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic              clock_i, rstn_i, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0]        paddr;
    logic [31:0]       pwdata, prdata, r, v;
    logic [2:0]        txd, rts_n, rx_valid, rxd, cts_n, ext_clk, ext_sel, tx_load;
    logic [2:0]        sout, ck_i, ck_o, ck_oe, hs_i, hs_o, hs_oe;
    logic [2:0][7:0]   rx_char, tx_data;
    logic [1:0]        sin_lo;
    logic              rise, node_line, collide, irq;
    int                err_total, num_checks;

    uart_line_opts i_uart_line_opts (.clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .eng_txd_i(txd),
        .eng_rts_n_i(rts_n), .rx_valid_i(rx_valid), .rx_char_i(rx_char),
        .xfer_clk_rise_i(rise), .eng_rxd_o(rxd), .eng_cts_n_o(cts_n),
        .eng_ext_clk_o(ext_clk), .eng_ext_sel_o(ext_sel), .tx_data_o(tx_data),
        .tx_load_o(tx_load), .serial_out_pin_o(sout), .serial_in_pin_i({node_line, sin_lo}),
        .transfer_clock_pin_i(ck_i), .transfer_clock_pin_o(ck_o),
        .transfer_clock_pin_oe_o(ck_oe), .hs_pin_i(hs_i), .hs_pin_o(hs_o),
        .hs_pin_oe_o(hs_oe), .irq_o(irq));

    remote_node i_remote_node (.clock_i(clock_i), .rstn_i(rstn_i), .line_i(sout[2]),
        .collide_i(collide), .line_o(node_line), .rise_o(rise));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, 200 MHz
    initial
    begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask

    // Expected character after channel two data inversion
    function automatic logic [31:0] inv8(input logic [7:0] c, input bit inv);
        return {24'h00_0000, inv ? ~c : c};
    endfunction

    // One APB transfer; an idle edge first keeps back-to-back calls apart
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        penable <= 1'b0;
        @(posedge clock_i);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready
        do
        begin
            @(posedge clock_i);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(r, exp);
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clock_i);
    endtask

    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Watchdog, far beyond the few hundred cycles the tests need
    initial
    begin
        #20us;
        err_total++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {rstn_i, psel, penable, pwrite, paddr, pwdata, rx_valid, rx_char} = '0;
        {txd, rts_n, hs_i} = '1;
        {sin_lo, ck_i, collide} = '0;
        v = $urandom(32'hc535);
        step(5);
        rstn_i <= 1'b1;
        step(1);
        rd(OFS_CTRL0, 32'h0000_0000);
        rd(OFS_STATUS, 32'h0000_0000);
        chk(irq, 0);
        rd(8'h7C, 32'h0000_0000);
        chk(e, 1);
        // Receive pin as input, random levels reach the engine
        sin_lo <= 2'($urandom);
        step(2);
        chk(rxd[1:0], sin_lo);
        apb(1'b1, OFS_DIR, 32'h0000_0025);
        apb(1'b1, OFS_PORT, 32'h0000_0024);
        sin_lo <= 2'b00;
        step(2);
        chk(rxd[0], 1);
        chk({ck_oe[1], ck_o[1]}, 2'b11);
        // External clock on channel zero; channel two stays internal
        apb(1'b1, OFS_CTRL0, 32'h0000_0008);
        apb(1'b1, OFS_CTRL2, 32'h0000_0008);
        ck_i <= 3'b111;
        step(2);
        chk(ext_sel, 3'b001);
        chk({ext_clk[0], ck_oe[0]}, 2'b10);
        // Handshake roles
        apb(1'b1, OFS_CTRL1, 32'h0000_0000);
        hs_i <= 3'b010;
        step(2);
        chk({cts_n[1], hs_oe[1]}, 2'b10);
        apb(1'b1, OFS_CTRL0, 32'h0000_0004);
        rts_n <= 3'b110;
        step(2);
        chk({hs_oe[0], hs_o[0]}, 2'b10);
        apb(1'b1, OFS_CTRL0, 32'h0000_0010);
        step(1);
        chk({hs_oe[0], hs_o[0]}, 2'b11);
        // Sleep filtering on channel zero, alternating top bit
        apb(1'b1, OFS_CTRL0, 32'h0000_0080);
        for (int i = 0; i < 8; i++)
        begin
            v = $urandom;
            v[7] = i[0];
            apb(1'b1, OFS_STATUS, 32'h0000_000F);
            rx_char[0] <= v[7:0];
            rx_char[1] <= v[7:0];
            rx_valid <= 3'b011;
            step(1);
            rx_valid <= 3'b000;
            step(1);
            rd(OFS_STATUS, {30'h0, 1'b1, v[7]});
            if (v[7]) rd(OFS_RXBUF0, inv8(v[7:0], 0));
        end
        // Channel two inversion both ways, framing untouched
        apb(1'b1, OFS_CTRL2, 32'h0000_0040);
        rd(OFS_CTRL2, 32'h0000_0040);
        v = $urandom;
        apb(1'b1, OFS_TXBUF2, v);
        step(1);
        chk({tx_load[2], tx_data[2]}, {1'b1, 8'(inv8(v[7:0], 1'b1))});
        // Channel zero never inverts its character bits
        apb(1'b1, OFS_TXBUF0, v);
        step(1);
        chk({tx_load[0], tx_data[0]}, {1'b1, v[7:0]});
        rx_char[2] <= v[15:8];
        rx_valid <= 3'b100;
        step(1);
        rx_valid <= 3'b000;
        step(1);
        rd(OFS_RXBUF2, inv8(v[15:8], 1'b1));
        txd <= 3'b000;
        step(2);
        chk(sout[2], 0);
        // Polarity reversal with collision detect, line echoed by the node
        apb(1'b1, OFS_CTRL2, 32'h0000_0300);
        apb(1'b1, OFS_STATUS, 32'h0000_000F);
        txd <= 3'($urandom);
        step(8);
        chk({sout[2], rxd[2]}, {~txd[2], txd[2]});
        rd(OFS_STATUS, 32'h0000_0000);
        apb(1'b1, OFS_MASK, 32'h0000_0008);
        collide <= 1'b1;
        step(8);
        chk(irq, 1);
        rd(OFS_STATUS, 32'h0000_0008);
        collide <= 1'b0;
        apb(1'b1, OFS_STATUS, 32'h0000_0008);
        step(1);
        chk(irq, 0);
        apb(1'b1, OFS_CTRL2, 32'h0000_0000);
        step(2);
        chk(sout[2], txd[2]);
        print_verdict();
    end
endmodule
`default_nettype wire
